// *** common/bcc_pkg.sv ***
`default_nettype none
package bcc_pkg;
  // Clock and base tick
  localparam int CLK_FREQ_MHZ = 50;
  localparam int BASE_TICK_NS = 8000;
  localparam int BASE_TICK_CYCLES = (BASE_TICK_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int TICK_NS = BASE_TICK_NS;

  // Ramp step times in microseconds, then in base ticks
  localparam int RAMP_SLOW_US = 32;
  localparam int RAMP_MID_US = 16;
  localparam int RAMP_FAST_US = 8;
  localparam logic [2:0] RAMP_SLOW_TICKS = 3'((RAMP_SLOW_US * 1000) / TICK_NS);
  localparam logic [2:0] RAMP_MID_TICKS = 3'((RAMP_MID_US * 1000) / TICK_NS);
  localparam logic [2:0] RAMP_FAST_TICKS = 3'((RAMP_FAST_US * 1000) / TICK_NS);

  // Soft-start step times in microseconds, then in base ticks
  localparam int SS_STEP0_US = 32;
  localparam int SS_STEP1_US = 64;
  localparam int SS_STEP2_US = 128;
  localparam int SS_STEP3_US = 256;
  localparam logic [5:0] SS_STEP0_TICKS = 6'((SS_STEP0_US * 1000) / TICK_NS);
  localparam logic [5:0] SS_STEP1_TICKS = 6'((SS_STEP1_US * 1000) / TICK_NS);
  localparam logic [5:0] SS_STEP2_TICKS = 6'((SS_STEP2_US * 1000) / TICK_NS);
  localparam logic [5:0] SS_STEP3_TICKS = 6'((SS_STEP3_US * 1000) / TICK_NS);
  localparam logic [2:0] SS_LAST_LEVEL = 3'h7;

  // Bus geometry; byte address is four times the register index
  localparam int ADDR_W = 18;
  localparam logic [15:0] BUCK1_SCALING_IDX = 16'h405a;
  localparam logic [15:0] BUCK2_CTRL1_IDX = 16'h405b;
  localparam logic [17:0] BUCK1_SCALING_ADDR = {BUCK1_SCALING_IDX, 2'b00};
  localparam logic [17:0] BUCK2_CTRL1_ADDR = {BUCK2_CTRL1_IDX, 2'b00};

  // Reset values
  localparam logic [15:0] BUCK1_SCALING_RST = 16'h0000;
  localparam logic [15:0] BUCK2_CTRL1_RST = 16'h9000;

  // Field masks
  localparam logic [15:0] BUCK1_RW_MASK = 16'h187f;
  localparam logic [15:0] BUCK2_BUS_MASK = 16'hd0b0;
  localparam logic [15:0] BUCK2_LOADER_MASK = 16'h0303;

  // Field positions
  localparam int SRC_LSB = 11;
  localparam int VSEL_LSB = 0;
  localparam int RATE_LSB = 14;
  localparam int PHASE_BIT = 12;
  localparam int FREQ_LSB = 8;
  localparam int FLOAT_BIT = 7;
  localparam int SS_LSB = 4;
  localparam int CAP_LSB = 0;

  // Field encodings
  localparam logic [1:0] SRC_DISABLED = 2'h0;
  localparam logic [1:0] SRC_REGISTER = 2'h1;
  localparam logic [1:0] SRC_HW_ONE = 2'h2;
  localparam logic [1:0] SRC_HW_TWO = 2'h3;
  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [1:0] RATE_IMMEDIATE = 2'h3;
  localparam logic [1:0] FREQ_2MHZ = 2'h1;
  localparam logic [1:0] FREQ_4MHZ = 2'h2;
  localparam logic [1:0] CAP_22_47UF = 2'h2;

  // Voltage code mapping, microvolts
  localparam int VMIN_UV = 600000;
  localparam int VSTEP_UV = 12500;
  localparam logic [6:0] VCODE_LO = 7'h08;
  localparam logic [6:0] VCODE_HI = 7'h68;
  localparam logic [6:0] VCODE_4MHZ_MAX = 7'h48;

  // Bus request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bcc_avs_req_t;

  // Configuration loader bundle
  typedef struct packed {
    logic active;
    logic valid;
    logic [1:0] freq;
    logic [1:0] cap;
  } bcc_loader_t;
endpackage
`default_nettype wire

// *** rtl/bcc_regs.sv ***
// Function
// - Scaling source: off, register, hw one, two
// - Target code maps 0.6V-1.8V, 12.5mV, clamped
// - Ramp one step per 32/16/8us or immediate
// - Phase bit inverts converter two clock
// - Frequency code 01 2MHz, 10 4MHz
// - Frequency and capacitor change only by loader
// - Float bit: discharge or float when disabled
// - Soft-start: eight steps of 32-256us each
// - Capacitor code 10 means 22-47uF
`timescale 1ns/1ns
`default_nettype none
module bcc_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire bcc_pkg::bcc_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire bcc_pkg::bcc_loader_t cfg_loader,
  input wire logic hw_scaling_input_one,
  input wire logic hw_scaling_input_two,
  input wire logic buck1_freq_4mhz,
  output logic buck1_scaling_active,
  output logic [20:0] buck1_target_uv,
  output logic buck1_target_over_limit,
  input wire logic [6:0] buck2_target_code,
  input wire logic buck2_enable,
  input wire logic buck2_switch_clk_raw,
  output logic [6:0] buck2_voltage_code,
  output logic [20:0] buck2_output_uv,
  output logic buck2_switch_clk,
  output logic buck2_freq_2mhz,
  output logic buck2_freq_4mhz,
  output logic buck2_freq_reserved,
  output logic buck2_discharge,
  output logic [2:0] buck2_softstart_level,
  output logic buck2_softstart_busy,
  output logic buck2_cap_valid
);

  // Clamp a code and turn it into microvolts
  function automatic logic [20:0] code_to_uv(input logic [6:0] code);
    logic [6:0] c;
    c = (code < bcc_pkg::VCODE_LO) ? bcc_pkg::VCODE_LO :
        (code > bcc_pkg::VCODE_HI) ? bcc_pkg::VCODE_HI : code;
    code_to_uv = 21'(bcc_pkg::VMIN_UV + (int'(c) - int'(bcc_pkg::VCODE_LO)) * bcc_pkg::VSTEP_UV);
  endfunction

  // Merge the low two byte lanes of a write into a word
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] be);
    lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic [15:0] buck1_scaling_control; // Converter one scaling word
  logic [15:0] buck2_control_one; // Converter two first control word
  logic bus_ack; // Second cycle of a bus access
  logic [8:0] base_cnt; // Divider for the 8us base tick
  logic [2:0] ramp_cnt; // Base ticks since last ramp step
  logic [5:0] ss_cnt; // Base ticks inside current soft-start step
  logic buck2_enable_q; // Previous enable, for edge detect

  // Bus decode
  wire logic bus_access = avs_req.read | avs_req.write;
  wire logic sel_buck1 = avs_req.address == bcc_pkg::BUCK1_SCALING_ADDR;
  wire logic sel_buck2 = avs_req.address == bcc_pkg::BUCK2_CTRL1_ADDR;
  wire logic bus_take = bus_access & bus_ack;
  wire logic wr_buck1 = bus_take & avs_req.write & sel_buck1;
  wire logic wr_buck2 = bus_take & avs_req.write & sel_buck2;
  wire logic [15:0] wr_data = avs_req.writedata[15:0];
  wire logic [1:0] wr_be = avs_req.byteenable[1:0];

  // One wait state: the slave answers on the second cycle
  assign avs_waitrequest = bus_access & ~bus_ack;

  // Unmapped reads answer zero
  wire logic [31:0] read_mux = sel_buck1 ? {16'h0000, buck1_scaling_control} :
                               sel_buck2 ? {16'h0000, buck2_control_one} : 32'h0000_0000;

  // Converter one next value: only documented bits are writable
  wire logic [15:0] buck1_merged = lane_merge(buck1_scaling_control, wr_data, wr_be);
  wire logic [15:0] next_buck1_scaling_control = wr_buck1 ?
                    (buck1_merged & bcc_pkg::BUCK1_RW_MASK) : buck1_scaling_control;

  // Converter two: loader word and bus word combined field by field
  wire logic loader_take = cfg_loader.active & cfg_loader.valid;
  wire logic [15:0] loader_word = {6'h00, cfg_loader.freq, 6'h00, cfg_loader.cap};
  wire logic [15:0] buck2_bus_word = wr_buck2 ?
                    lane_merge(buck2_control_one, wr_data, wr_be) : buck2_control_one;
  wire logic [15:0] buck2_ld_word = loader_take ? loader_word : buck2_control_one;
  // Bus data never reaches the loader-only bits; only the BUCK2_BUS_MASK bits land
  wire logic [15:0] next_buck2_control_one = (buck2_bus_word & bcc_pkg::BUCK2_BUS_MASK) |
                                             (buck2_ld_word & bcc_pkg::BUCK2_LOADER_MASK);

  // Field views
  wire logic [1:0] f_src = buck1_scaling_control[bcc_pkg::SRC_LSB +: 2];
  wire logic [6:0] f_vsel = buck1_scaling_control[bcc_pkg::VSEL_LSB +: 7];
  wire logic [1:0] f_rate = buck2_control_one[bcc_pkg::RATE_LSB +: 2];
  wire logic f_phase = buck2_control_one[bcc_pkg::PHASE_BIT];
  wire logic [1:0] f_freq = buck2_control_one[bcc_pkg::FREQ_LSB +: 2];
  wire logic f_float = buck2_control_one[bcc_pkg::FLOAT_BIT];
  wire logic [1:0] f_ss = buck2_control_one[bcc_pkg::SS_LSB +: 2];
  wire logic [1:0] f_cap = buck2_control_one[bcc_pkg::CAP_LSB +: 2];

  // Scaling source selection
  logic scaling_sel;
  always_comb begin
    case (f_src)
      bcc_pkg::SRC_DISABLED: scaling_sel = 1'b0;
      bcc_pkg::SRC_REGISTER: scaling_sel = 1'b1;
      bcc_pkg::SRC_HW_ONE: scaling_sel = hw_scaling_input_one;
      bcc_pkg::SRC_HW_TWO: scaling_sel = hw_scaling_input_two;
      default: scaling_sel = 1'b0;
    endcase
  end

  // Base ticks per ramp step
  logic [2:0] ramp_ticks;
  always_comb begin
    case (f_rate)
      bcc_pkg::RATE_SLOW: ramp_ticks = bcc_pkg::RAMP_SLOW_TICKS;
      bcc_pkg::RATE_MID: ramp_ticks = bcc_pkg::RAMP_MID_TICKS;
      bcc_pkg::RATE_FAST: ramp_ticks = bcc_pkg::RAMP_FAST_TICKS;
      default: ramp_ticks = bcc_pkg::RAMP_FAST_TICKS;
    endcase
  end

  // Base ticks per soft-start step
  logic [5:0] ss_ticks;
  always_comb begin
    case (f_ss)
      2'h0: ss_ticks = bcc_pkg::SS_STEP0_TICKS;
      2'h1: ss_ticks = bcc_pkg::SS_STEP1_TICKS;
      2'h2: ss_ticks = bcc_pkg::SS_STEP2_TICKS;
      default: ss_ticks = bcc_pkg::SS_STEP3_TICKS;
    endcase
  end

  // Timing enables
  wire logic base_tick = base_cnt == 9'(bcc_pkg::BASE_TICK_CYCLES - 1);
  wire logic ramp_immediate = f_rate == bcc_pkg::RATE_IMMEDIATE;
  wire logic ramp_step = base_tick & (ramp_cnt == ramp_ticks - 3'h1);
  wire logic ss_start = buck2_enable & ~buck2_enable_q;
  wire logic ss_step = buck2_softstart_busy & base_tick & (ss_cnt == ss_ticks - 6'h01);

  // Next output voltage code moves one code toward the target per step, or jumps straight to it in immediate mode
  wire logic [6:0] next_buck2_voltage_code =
      ramp_immediate ? buck2_target_code :
      !ramp_step ? buck2_voltage_code :
      (buck2_voltage_code < buck2_target_code) ? buck2_voltage_code + 7'h01 :
      (buck2_voltage_code > buck2_target_code) ? buck2_voltage_code - 7'h01 :
      buck2_voltage_code;

  // Register file and bus handshake
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buck1_scaling_control <= bcc_pkg::BUCK1_SCALING_RST;
      buck2_control_one <= bcc_pkg::BUCK2_CTRL1_RST;
      bus_ack <= 1'b0;
    end else begin
      buck1_scaling_control <= next_buck1_scaling_control;
      buck2_control_one <= next_buck2_control_one;
      bus_ack <= bus_access & ~bus_ack;
    end
  end

  // Read data captured in the wait cycle, held through the answer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_waitrequest) begin
      avs_readdata <= read_mux;
    end
  end

  // Base tick divider, free running
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      base_cnt <= 9'h000;
    end else if (base_tick) begin
      base_cnt <= 9'h000;
    end else begin
      base_cnt <= base_cnt + 9'h001;
    end
  end

  // Ramp interval counter; restarts when the step fires
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ramp_cnt <= 3'h0;
    end else if (ramp_step || ramp_immediate) begin
      ramp_cnt <= 3'h0;
    end else if (base_tick) begin
      ramp_cnt <= ramp_cnt + 3'h1;
    end
  end

  // Ramped output code
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buck2_voltage_code <= 7'h00;
    end else begin
      buck2_voltage_code <= next_buck2_voltage_code;
    end
  end

  // Soft-start sequencer: eight levels, then idle at full limit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buck2_enable_q <= 1'b0;
      buck2_softstart_busy <= 1'b0;
      buck2_softstart_level <= 3'h0;
      ss_cnt <= 6'h00;
    end else begin
      buck2_enable_q <= buck2_enable;
      if (!buck2_enable) begin
        // Disable aborts any sequence in progress
        buck2_softstart_busy <= 1'b0;
        buck2_softstart_level <= 3'h0;
        ss_cnt <= 6'h00;
      end else if (ss_start) begin
        buck2_softstart_busy <= 1'b1;
        buck2_softstart_level <= 3'h0;
        ss_cnt <= 6'h00;
      end else if (ss_step) begin
        ss_cnt <= 6'h00;
        if (buck2_softstart_level == bcc_pkg::SS_LAST_LEVEL) begin
          buck2_softstart_busy <= 1'b0;
        end else begin
          buck2_softstart_level <= buck2_softstart_level + 3'h1;
        end
      end else if (buck2_softstart_busy && base_tick) begin
        ss_cnt <= ss_cnt + 6'h01;
      end
    end
  end

  // Registered decodes toward the analogue side
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buck1_scaling_active <= 1'b0;
      buck1_target_uv <= 21'h00_0000;
      buck1_target_over_limit <= 1'b0;
      buck2_output_uv <= 21'h00_0000;
    end else begin
      buck1_scaling_active <= scaling_sel;
      buck1_target_uv <= code_to_uv(f_vsel);
      // Flags a code that software must not use in 4MHz mode
      buck1_target_over_limit <= buck1_freq_4mhz & (f_vsel > bcc_pkg::VCODE_4MHZ_MAX);
      buck2_output_uv <= code_to_uv(buck2_voltage_code);
    end
  end

  // Converter two mode decodes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buck2_switch_clk <= 1'b0;
      buck2_freq_2mhz <= 1'b0;
      buck2_freq_4mhz <= 1'b0;
      buck2_freq_reserved <= 1'b1;
      buck2_discharge <= 1'b0;
      buck2_cap_valid <= 1'b0;
    end else begin
      // Adds one cycle of delay to the switching clock
      buck2_switch_clk <= buck2_switch_clk_raw ^ f_phase;
      buck2_freq_2mhz <= f_freq == bcc_pkg::FREQ_2MHZ;
      buck2_freq_4mhz <= f_freq == bcc_pkg::FREQ_4MHZ;
      buck2_freq_reserved <= (f_freq != bcc_pkg::FREQ_2MHZ) && (f_freq != bcc_pkg::FREQ_4MHZ);
      buck2_discharge <= ~buck2_enable & ~f_float;
      buck2_cap_valid <= f_cap == bcc_pkg::CAP_22_47UF;
    end
  end

endmodule
`default_nettype wire

// *** verif/bcc_regs_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcc_regs_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire bcc_pkg::bcc_avs_req_t avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire bcc_pkg::bcc_loader_t cfg_loader,
  input wire logic hw_scaling_input_one,
  input wire logic hw_scaling_input_two,
  input wire logic buck1_freq_4mhz,
  input wire logic buck1_scaling_active,
  input wire logic [20:0] buck1_target_uv,
  input wire logic buck1_target_over_limit,
  input wire logic buck2_enable,
  input wire logic buck2_switch_clk_raw,
  input wire logic [6:0] buck2_voltage_code,
  input wire logic [20:0] buck2_output_uv,
  input wire logic buck2_switch_clk,
  input wire logic buck2_freq_2mhz,
  input wire logic buck2_freq_4mhz,
  input wire logic buck2_discharge,
  input wire logic [2:0] buck2_softstart_level,
  input wire logic buck2_softstart_busy,
  input wire logic buck2_cap_valid
);
  // Shadow words; loader bits kept apart so a same-edge bus write cannot clobber them
  logic [15:0] sh1;
  logic [15:0] sh2b;
  logic [15:0] sh2l;
  wire logic [15:0] sh2 = sh2b | sh2l;
  wire logic wr_ok = avs_req.write && !avs_waitrequest;
  wire logic [15:0] bem = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
  wire logic [15:0] wd = avs_req.writedata[15:0] & bem;
  wire logic hit1 = avs_req.address == bcc_pkg::BUCK1_SCALING_ADDR;
  wire logic hit2 = avs_req.address == bcc_pkg::BUCK2_CTRL1_ADDR;
  wire logic [15:0] rexp = hit1 ? sh1 : (hit2 ? sh2 : 16'h0000);
  wire logic [1:0] src = sh1[12:11];
  wire logic act = src == 2'h1 || (src == 2'h2 && hw_scaling_input_one) || (src == 2'h3 && hw_scaling_input_two);
  // Clamped linear code to microvolt map
  function automatic logic [20:0] uv(input logic [6:0] c);
    if (c <= 7'h08) return 21'h9_27c0;
    if (c >= 7'h68) return 21'h1b_7740;
    return 21'(32'h9_27c0 + 32'h30d4 * (int'(c) - 8));
  endfunction
  // Track what each word must hold
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sh1 <= bcc_pkg::BUCK1_SCALING_RST;
      sh2b <= bcc_pkg::BUCK2_CTRL1_RST;
      sh2l <= 16'h0000;
    end else begin
      if (wr_ok && hit1) sh1 <= (sh1 & ~(bem & bcc_pkg::BUCK1_RW_MASK)) | (wd & bcc_pkg::BUCK1_RW_MASK);
      if (wr_ok && hit2) sh2b <= (sh2b & ~(bem & bcc_pkg::BUCK2_BUS_MASK)) | (wd & bcc_pkg::BUCK2_BUS_MASK);
      if (cfg_loader.active && cfg_loader.valid) sh2l <= {6'h00, cfg_loader.freq, 6'h00, cfg_loader.cap};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_WAIT_FIRST: assert property ($rose(avs_req.read || avs_req.write) |-> avs_waitrequest) else $error("no wait");
  AST_WAIT_ONE: assert property ((avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  AST_RDATA: assert property (avs_req.read && !avs_waitrequest |-> avs_readdata == {16'h0000, rexp})
    else $error("read data");
  AST_B1_UV: assert property ($past(rst_b) |-> buck1_target_uv == uv($past(sh1[6:0]))) else $error("uv one");
  AST_B2_UV: assert property ($past(rst_b) |-> buck2_output_uv == uv($past(buck2_voltage_code)))
    else $error("uv two");
  AST_LIMIT: assert property ($past(rst_b) |-> buck1_target_over_limit == $past(buck1_freq_4mhz && sh1[6:0] > 7'h48))
    else $error("limit");
  AST_SCALE: assert property ($past(rst_b) |-> buck1_scaling_active == $past(act)) else $error("source");
  AST_PHASE: assert property ($past(rst_b) |-> buck2_switch_clk == $past(buck2_switch_clk_raw ^ sh2[12]))
    else $error("phase");
  AST_FLOAT: assert property ($past(rst_b) |-> buck2_discharge == $past(!buck2_enable && !sh2[7]))
    else $error("discharge");
  AST_DECODE: assert property ($past(rst_b) |-> {buck2_freq_2mhz, buck2_freq_4mhz, buck2_cap_valid} ==
    $past({sh2[9:8] == 2'h1, sh2[9:8] == 2'h2, sh2[1:0] == 2'h2})) else $error("decode");
  AST_RAMP: assert property (sh2[15:14] != 2'h3 |=>
    (7'(buck2_voltage_code - $past(buck2_voltage_code)) inside {7'h00, 7'h01, 7'h7f})) else $error("ramp");
  AST_SS_GO: assert property ($rose(buck2_enable) |=> buck2_softstart_busy && buck2_softstart_level == 3'h0)
    else $error("ss start");
  AST_SS_OFF: assert property (!buck2_enable |=> !buck2_softstart_busy && buck2_softstart_level == 3'h0)
    else $error("ss off");
endmodule
bind bcc_regs bcc_regs_sva chk_u (.*);
`default_nettype wire

// *** verif/bcc_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcc_regs_tb;
  logic clk, rst_b, avs_waitrequest, hw_scaling_input_one, hw_scaling_input_two, buck1_freq_4mhz;
  logic buck1_scaling_active, buck1_target_over_limit, buck2_enable, buck2_switch_clk;
  logic buck2_switch_clk_raw = 1'b0; // Only the toggle process below drives it
  logic buck2_freq_2mhz, buck2_freq_4mhz, buck2_freq_reserved, buck2_discharge, buck2_softstart_busy, buck2_cap_valid;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic [20:0] buck1_target_uv, buck2_output_uv;
  logic [6:0] buck2_target_code, buck2_voltage_code;
  logic [2:0] buck2_softstart_level;
  bcc_pkg::bcc_avs_req_t avs_req;
  bcc_pkg::bcc_loader_t cfg_loader;
  int fail_count, check_count, n;
  localparam logic [17:0] A1 = bcc_pkg::BUCK1_SCALING_ADDR;
  localparam logic [17:0] A2 = bcc_pkg::BUCK2_CTRL1_ADDR;
  localparam int LVL = 4 * bcc_pkg::BASE_TICK_CYCLES;
  logic [6:0] vc [5] = '{7'h00, 7'h09, 7'h48, 7'h49, 7'h7f};
  logic [20:0] vu [5] = '{21'h9_27c0, 21'h9_5894, 21'h15_5cc0, 21'h15_8d94, 21'h1b_7740};
  bcc_regs dut_u (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Free-running raw switching clock
  always @(posedge clk) buck2_switch_clk_raw <= ~buck2_switch_clk_raw;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus access; held until waitrequest is sampled low at a rising edge, data taken at that edge
  task automatic acc(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clk);
    avs_req <= {!w, w, a, {16'h0000, d}, be};
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (k >= 40) fail_count++;
    q = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task automatic rc(input logic [17:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000, 4'hf);
    chk("readback", q, {16'h0000, e});
  endtask
  // Ends at a falling edge, where registered outputs are settled
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic load(input logic [1:0] f, input logic [1:0] c);
    @(posedge clk);
    cfg_loader <= {1'b1, 1'b1, f, c};
    @(posedge clk);
    cfg_loader <= {1'b0, 1'b0, f, c};
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog, well beyond the soft-start run
  initial begin
    #(50000 * 20);
    fail_count++;
    end_of_test();
  end
  initial begin
    {rst_b, hw_scaling_input_one, hw_scaling_input_two, buck1_freq_4mhz, buck2_enable} = '0;
    {avs_req, cfg_loader, buck2_target_code} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rc(A1, 16'h0000);
    rc(A2, 16'h9000);
    wr(A2, 16'hffff);
    rc(A2, 16'hd0b0);
    wr(18'h0_0000, 16'hffff);
    rc(18'h0_0000, 16'h0000);
    // Every loader code, both fields
    for (int i = 0; i < 4; i++) begin
      load(i[1:0], i[1:0]);
      settle(2);
      chk("decode", {buck2_freq_2mhz, buck2_freq_4mhz, buck2_freq_reserved, buck2_cap_valid},
        {i == 1, i == 2, i == 0 || i == 3, i == 2});
    end
    rc(A2, 16'hd3b3);
    wr(A2, 16'h0000);
    rc(A2, 16'h0303);
    settle(2);
    chk("discharge", buck2_discharge, 1'b1);
    wr(A2, 16'h0080);
    settle(2);
    chk("float", buck2_discharge, 1'b0);
    acc(1'b1, A1, 16'hffff, 4'h1);
    rc(A1, 16'h007f);
    buck1_freq_4mhz <= 1'b1;
    // Each source code against both pin states
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        wr(A1, {3'b000, i[1:0], 11'h009});
        hw_scaling_input_one <= !j[0];
        hw_scaling_input_two <= j[0];
        settle(3);
        chk("source", buck1_scaling_active, i == 1 || (i == 2 && j == 0) || (i == 3 && j == 1));
      end
    end
    for (int k = 0; k < 5; k++) begin
      wr(A1, {9'h000, vc[k]});
      settle(3);
      chk("target", buck1_target_uv, vu[k]);
      chk("limit", buck1_target_over_limit, vc[k] > 7'h48);
    end
    wr(A2, 16'hc000);
    buck2_target_code <= 7'h20;
    settle(1);
    chk("jump", buck2_voltage_code, 7'h20);
    wr(A2, 16'h8000);
    buck2_target_code <= 7'h22;
    settle(5);
    chk("early", buck2_voltage_code == 7'h22, 1'b0);
    settle(2 * bcc_pkg::BASE_TICK_CYCLES + 10);
    chk("ramp", buck2_voltage_code, 7'h22);
    chk("out", buck2_output_uv, 21'he_1d48);
    // Soft-start with the shortest step: eight levels
    @(posedge clk);
    buck2_enable <= 1'b1;
    settle(1);
    chk("busy", {buck2_softstart_busy, buck2_softstart_level}, 4'h8);
    n = 0;
    while (buck2_softstart_busy === 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("sslen", n > 8 * LVL - bcc_pkg::BASE_TICK_CYCLES - 2 && n <= 8 * LVL + 2, 1'b1);
    chk("sslvl", buck2_softstart_level, 3'h7);
    @(posedge clk);
    buck2_enable <= 1'b0;
    settle(1);
    chk("ssoff", {buck2_softstart_busy, buck2_softstart_level}, 4'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
